/* File: rtl/wdt_delay.sv */
`timescale 1ns/1ps
// Counts the fixed delay between timeout and reset
module wdt_delay
    import wdt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic cancel,
    output logic done
);
    logic [WDT_DLY_W-1:0] cnt;
    logic [WDT_DLY_W-1:0] next_cnt;
    logic next_done;

    always_comb begin
        next_cnt = cnt;
        next_done = 1'b0;
        if (cancel) begin
            next_cnt = '0;
        end else if (start) begin
            next_cnt = WDT_RST_DELAY - 10'h001;
        end else if (cnt != '0) begin
            next_cnt = cnt - 10'h001;
            next_done = (cnt == 10'h001);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= '0;
            done <= 1'b0;
        end else begin
            cnt <= next_cnt;
            done <= next_done;
        end
    end
endmodule

/* File: rtl/wdt_pkg.sv */
// Functional notes
// - The watchdog is a free-running counter that software restarts now and then.
// - A two-bit timeout select picks 2^15, 2^18, 2^21 or 2^24 clock cycles.
// - On timeout, an interrupt request is raised if the interrupt is enabled.
// - The timeout starts a reset delay that ends exactly 512 cycles later.
// - If no restart came and enable stayed high before the delay ends, a system reset is asserted.
package wdt_pkg;
    localparam int WDT_CNT_W = 24;
    localparam int WDT_DLY_W = 10;
    localparam logic [4:0] WDT_EXP_SEL0 = 5'h0F;
    localparam logic [4:0] WDT_EXP_SEL1 = 5'h12;
    localparam logic [4:0] WDT_EXP_SEL2 = 5'h15;
    localparam logic [4:0] WDT_EXP_SEL3 = 5'h18;
    localparam logic [9:0] WDT_RST_DELAY = 10'h200;
    localparam logic [23:0] WDT_CNT_RESET = 24'h00_0000;
    localparam logic [1:0] WDT_SEL_RESET = 2'h0;
    typedef enum logic [1:0] {WDT_RUN, WDT_DELAY, WDT_FIRED} wdt_state_t;
endpackage

/* File: rtl/wdt_top.sv */
`timescale 1ns/1ps
module wdt_top
    import wdt_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic [1:0] timeout_select,
    input wire logic irq_enable,
    input wire logic restart,
    output logic timeout_flag,
    output logic irq,
    output logic sys_reset
);
    wdt_state_t state;
    wdt_state_t next_state;
    logic [WDT_CNT_W-1:0] cnt;
    logic [WDT_CNT_W-1:0] next_cnt;
    logic next_flag;
    logic next_sys_reset;
    logic [4:0] exp_sel;
    logic expire;
    logic dly_start;
    logic dly_done;

    always_comb begin
        unique case (timeout_select)
            2'h0: exp_sel = WDT_EXP_SEL0;
            2'h1: exp_sel = WDT_EXP_SEL1;
            2'h2: exp_sel = WDT_EXP_SEL2;
            2'h3: exp_sel = WDT_EXP_SEL3;
        endcase
    end

    // Last count of the selected period
    assign expire = (cnt == ((WDT_CNT_W'(1) << exp_sel) - WDT_CNT_W'(1)));

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_flag = timeout_flag;
        next_sys_reset = 1'b0;
        dly_start = 1'b0;
        if (restart || !enable) begin
            next_state = WDT_RUN;
            next_cnt = WDT_CNT_RESET;
            next_flag = 1'b0;
        end else begin
            unique case (state)
                WDT_RUN: begin
                    next_cnt = cnt + WDT_CNT_W'(1);
                    if (expire) begin
                        next_cnt = WDT_CNT_RESET;
                        next_flag = 1'b1;
                        dly_start = 1'b1;
                        next_state = WDT_DELAY;
                    end
                end
                WDT_DELAY: begin
                    if (dly_done) begin
                        next_sys_reset = 1'b1;
                        next_state = WDT_FIRED;
                    end
                end
                WDT_FIRED: begin
                    next_sys_reset = 1'b1;
                end
                // Unused state code falls back to counting
                default: begin
                    next_state = WDT_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= WDT_RUN;
            cnt <= WDT_CNT_RESET;
            timeout_flag <= 1'b0;
            sys_reset <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            timeout_flag <= next_flag;
            sys_reset <= next_sys_reset;
        end
    end

    assign irq = timeout_flag && irq_enable;

    wdt_delay u_delay (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .start(dly_start),
        .cancel(restart || !enable),
        .done(dly_done)
    );
endmodule

/* File: tb/test_watchdog_timeout_reset.sv */
`timescale 1ns/1ps
module test_watchdog_timeout_reset;
    logic sys_clk = 0, rst_b = 0, enable = 0, irq_enable = 0, restart = 0;
    logic [1:0] timeout_select = 2'h0;
    logic timeout_flag, irq, sys_reset;
    int err_count = 0, cmp_count = 0, n;
    always #50 sys_clk = ~sys_clk;
    wdt_top wdt_top_inst (.sys_clk(sys_clk), .rst_b(rst_b), .enable(enable),
        .timeout_select(timeout_select), .irq_enable(irq_enable),
        .restart(restart), .timeout_flag(timeout_flag), .irq(irq),
        .sys_reset(sys_reset));
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %0d got %0d", s, e, g);
        end
    endtask
    // Counts edges until the chosen output goes high
    task automatic wait_for(bit rst);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end
        while ((rst ? sys_reset : timeout_flag) !== 1'b1 && n < 40000);
    endtask
    task automatic pulse_restart;
        restart = 1;
        @(posedge sys_clk);
        #1 restart = 0;
    endtask
    task automatic test_timeout;
        irq_enable = 1;
        enable = 1;
        wait_for(0);
        chk("timeout", 32'h0000_8000, n);
        chk("irq", 32'h0000_0001, irq);
        wait_for(1);
        chk("delay", 32'h0000_0200, n);
        pulse_restart;
        chk("flag", 32'h0000_0000, timeout_flag | sys_reset);
        $display("test_timeout done");
    endtask
    // Longer select must not end at the shortest period
    task automatic test_restart;
        irq_enable = 0;
        timeout_select = 2'h1;
        repeat (32770) @(posedge sys_clk);
        #1 chk("sel1 early", 32'h0000_0000, timeout_flag);
        timeout_select = 2'h0;
        pulse_restart;
        wait_for(0);
        chk("restart", 32'h0000_8000, n);
        chk("irq off", 32'h0000_0000, irq);
        $display("test_restart done");
    endtask
    // Dropping enable inside the delay must cancel the reset
    task automatic test_enable;
        repeat (100) @(posedge sys_clk);
        #1 enable = 0;
        @(posedge sys_clk);
        #1 chk("enable off", 32'h0000_0000, timeout_flag);
        repeat (600) @(posedge sys_clk);
        #1 chk("no reset", 32'h0000_0000, sys_reset);
        $display("test_enable done");
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        #1 rst_b = 1;
        @(posedge sys_clk); #1;
        test_timeout;
        test_restart;
        test_enable;
        stop_test;
    end
    initial begin
        #10_100_000 err_count++;
        stop_test;
    end
endmodule

/* File: tb/wdt_chk.sv */
`timescale 1ns/1ps
module wdt_chk (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic [1:0] timeout_select,
    input wire logic irq_enable,
    input wire logic restart,
    input wire logic timeout_flag,
    input wire logic irq,
    input wire logic sys_reset
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence s_quiet; !timeout_flag [*8]; endsequence
    a_irq_gate: assert property (irq == (timeout_flag && irq_enable))
        else $error("irq gating wrong");
    a_restart_clr: assert property (restart |=> !timeout_flag && !sys_reset)
        else $error("restart did not clear");
    a_no_early: assert property (restart |=> s_quiet)
        else $error("timeout soon after restart");
    a_flag_hold: assert property (timeout_flag && enable
        && !restart |=> timeout_flag)
        else $error("flag dropped");
    a_reset_time: assert property ($rose(sys_reset) |->
        $past(timeout_flag, 512) && !$past(timeout_flag, 513))
        else $error("reset delay wrong");
    a_reset_cause: assert property (sys_reset |-> timeout_flag)
        else $error("reset without timeout");
    a_reset_hold: assert property (sys_reset && enable
        && !restart |=> sys_reset)
        else $error("reset dropped");
    a_disable_clr: assert property (!enable
        |=> !timeout_flag && !sys_reset)
        else $error("disable did not clear");
endmodule
bind wdt_top wdt_chk wdt_chk_inst (.*);
